//--- rtl/aaipc_defines.svh
// Constants for the multi-use pin and analog output control block.
// Assumes a 250 MHz system clock and a 16-bit converter.
`ifndef AAIPC_DEFINES_SVH
`define AAIPC_DEFINES_SVH
// ****************************************
// Register indexes
// ****************************************
`define AAIPC_A_PIN3   4'h0
`define AAIPC_A_GROUP  4'h1
`define AAIPC_A_MEAN   4'h2
`define AAIPC_A_SIG    4'h3
`define AAIPC_A_ANGLE  4'h4
`define AAIPC_A_RANGE  4'h5
`define AAIPC_A_FIXED  4'h6
`define AAIPC_A_IVL    4'h7
`define AAIPC_A_PIN1   4'h8
`define AAIPC_A_PIN4   4'h9
`define AAIPC_A_STAT   4'hA
`define AAIPC_A_ADC    4'hB
// ****************************************
// Limits and reset values
// ****************************************
`define AAIPC_FN_MAX    5'h14
`define AAIPC_P14_MAX   3'h4
`define AAIPC_SIG_OFF   2'h2
`define AAIPC_MEAN_MAX  2'h3
`define AAIPC_AO_MAX    2'h2
`define AAIPC_RANGE_RST 7'h3C
`define AAIPC_RANGE_MIN 7'h01
`define AAIPC_RANGE_MAX 7'h64
`define AAIPC_IVL_RST   9'h032
`define AAIPC_IVL_MAX   9'h100
// ****************************************
// Pin function codes
// ****************************************
`define AAIPC_FN_AIN    5'h01
`define AAIPC_FN_VT     5'h03
`define AAIPC_FN_FILL   5'h05
`define AAIPC_FN_LOW    5'h06
`define AAIPC_FN_HIGH   5'h07
`define AAIPC_FN_HT_P   5'h08
`define AAIPC_FN_HT_N   5'h09
`define AAIPC_FN_HT_PU  5'h0A
`define AAIPC_FN_HT_ND  5'h0B
`define AAIPC_FN_HT_PD  5'h0C
`define AAIPC_FN_HT_NU  5'h0D
`define AAIPC_FN_TRIG   5'h0E
`define AAIPC_FN_CONT   5'h0F
`define AAIPC_FN_BST_H  5'h10
`define AAIPC_FN_BST_L  5'h11
`define AAIPC_FN_DIR    5'h12
`define AAIPC_FN_HST_A  5'h13
`define AAIPC_FN_HST_B  5'h14
// ****************************************
// Scaling and timing
// ****************************************
`define AAIPC_FILL_PCT  7'h50
`define AAIPC_DIR_LIM   9'h0AA
`define AAIPC_DEG360    10'h168
`define AAIPC_SPAN540   10'h21C
`define AAIPC_SPAN720   10'h2D0
`define AAIPC_OFS_WEST  10'h05A
`define AAIPC_OFS_SOUTH 10'h0B4
`define AAIPC_VT_OFS    16'h0190
`define AAIPC_VT_SPAN   16'h04B0
`define AAIPC_SPD_LSB   16'h000A
`define AAIPC_FULL      16'hFFFF
`define AAIPC_HALF      16'h8000
`define AAIPC_HALF_MAG  16'h7FFF
`define AAIPC_CLK_NS    4
`define AAIPC_MS_NS     1000000
`endif

//--- rtl/aaipc_pkg.sv
// Types shared by the pin control block and its surroundings.
// Assumes the constants header is compiled alongside.
package aaipc_pkg;
   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } aaipc_bus_t;

   typedef struct packed {
      logic out;
      logic oe;
      logic pull_up;
      logic pull_down;
   } aaipc_pin_t;

   typedef struct packed {
      logic [15:0] speed;
      logic [15:0] dir;
      logic [15:0] temp;
      logic        temp_en;
   } aaipc_dac_t;
endpackage

//--- rtl/aaipc_pin_ctrl.sv
// Multi-use pin function control, analog output scaling and update pacing.
// Assumes a synchronous register port and an external converter handshake.
`timescale 1ns/100ps
`default_nettype none
`include "aaipc_defines.svh"

module aaipc_pin_ctrl #(
   parameter int CYC_PER_MS = `AAIPC_MS_NS / `AAIPC_CLK_NS
) (
   input  wire logic                     clk_sys,
   input  wire logic                     rst_n,
   input  wire aaipc_pkg::aaipc_bus_t    bus,
   output var  logic [15:0]              rdata,
   input  wire logic                     half_duplex,
   input  wire logic                     pin_in,
   output var  aaipc_pkg::aaipc_pin_t    pin,
   input  wire logic [11:0]              wind_speed,
   input  wire logic signed [12:0]       wind_ew,
   input  wire logic signed [12:0]       wind_ns,
   input  wire logic [8:0]               wind_direction,
   input  wire logic signed [10:0]       sound_temperature,
   input  wire logic [6:0]               fill_pct,
   input  wire logic                     heating_on,
   input  wire logic                     meas_done,
   input  wire logic                     conv_done,
   input  wire logic [15:0]              adc_code,
   output var  logic                     heat_enable,
   output var  logic                     meas_start,
   output var  logic                     burst_start,
   output var  logic                     cont_run,
   output var  logic                     conv_start,
   output var  logic                     calc_enable,
   output var  logic                     vector_speed,
   output var  logic                     vector_angle,
   output var  aaipc_pkg::aaipc_dac_t    dac
);
   import aaipc_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [4:0]  pin3;
      logic [2:0]  pin1;
      logic [2:0]  pin4;
      logic        group;
      logic [1:0]  mean;
      logic [1:0]  sig;
      logic [1:0]  angle;
      logic [6:0]  range;
      logic [15:0] fixed;
      logic [8:0]  ivl;
      logic        sy1;
      logic        sy2;
      logic        sy3;
      logic        fill_seen;
      logic        burst_busy;
      logic        conv_busy;
      logic [17:0] ms_cnt;
      logic [8:0]  ivl_cnt;
      logic [15:0] adc_val;
      logic [15:0] rdata;
      aaipc_pin_t  pin;
      logic        heat;
      logic        meas_start;
      logic        burst_start;
      logic        cont_run;
      logic        conv_start;
      logic        calc;
      logic        vspd;
      logic        vang;
      aaipc_dac_t  dac;
   } aaipc_state_t;

   aaipc_state_t s;
   aaipc_state_t next_s;

   // ****************************************
   // Scaling helpers
   // ****************************************
   function automatic logic [15:0] scale(input logic [15:0] mag,
                                         input logic [15:0] full,
                                         input logic [15:0] top);
      logic [31:0] p;
      p = {16'h0000, mag} * {16'h0000, top};
      if (mag >= full) begin
         scale = top;
      end else begin
         scale = 16'(p / {16'h0000, full});
      end
   endfunction

   // Two-sided component: zero lands on mid span
   function automatic logic [15:0] comp(input logic signed [12:0] v,
                                        input logic [15:0] full);
      logic [12:0] m;
      logic [15:0] k;
      m = v[12] ? (~v + 13'h0001) : v;
      k = scale({3'h0, m}, full, `AAIPC_HALF_MAG);
      comp = v[12] ? (`AAIPC_HALF - k) : (`AAIPC_HALF + k);
   endfunction

   logic        rise;
   logic        lvl;
   logic        alloff;
   logic [15:0] full;
   logic [9:0]  adj;
   logic [9:0]  span;
   logic [15:0] tt;
   logic        ms_tick;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_s = s;
      next_s.meas_start = 1'b0;
      next_s.burst_start = 1'b0;
      next_s.conv_start = 1'b0;
      next_s.rdata = 16'h0000;

      // Second stage gives the level; second and third give the edge
      next_s.sy1 = pin_in;
      next_s.sy2 = s.sy1;
      next_s.sy3 = s.sy2;
      lvl = s.sy2;
      rise = s.sy2 & ~s.sy3;

      // Register writes; out-of-range values are dropped
      if (bus.wr) begin
         unique case (bus.addr)
            `AAIPC_A_PIN3: begin
               if (bus.wdata <= {11'h000, `AAIPC_FN_MAX}) begin
                  next_s.pin3 = bus.wdata[4:0];
               end
            end
            `AAIPC_A_GROUP: begin
               if (bus.wdata[15:1] == 15'h0000) begin
                  next_s.group = bus.wdata[0];
               end
            end
            `AAIPC_A_MEAN: begin
               if (bus.wdata[15:2] == 14'h0000) begin
                  next_s.mean = bus.wdata[1:0];
               end
            end
            `AAIPC_A_SIG: begin
               if (half_duplex && bus.wdata <= {14'h0000, `AAIPC_SIG_OFF}) begin
                  next_s.sig = bus.wdata[1:0];
               end
            end
            `AAIPC_A_ANGLE: begin
               if (bus.wdata <= {14'h0000, `AAIPC_AO_MAX}) begin
                  next_s.angle = bus.wdata[1:0];
               end
            end
            `AAIPC_A_RANGE: begin
               if (bus.wdata >= {9'h000, `AAIPC_RANGE_MIN}
                   && bus.wdata <= {9'h000, `AAIPC_RANGE_MAX}) begin
                  next_s.range = bus.wdata[6:0];
               end
            end
            `AAIPC_A_FIXED: next_s.fixed = bus.wdata;
            `AAIPC_A_IVL: begin
               if (bus.wdata <= {7'h00, `AAIPC_IVL_MAX}) begin
                  next_s.ivl = bus.wdata[8:0];
               end
            end
            `AAIPC_A_PIN1: begin
               if (bus.wdata <= {13'h0000, `AAIPC_P14_MAX}) begin
                  next_s.pin1 = bus.wdata[2:0];
               end
            end
            `AAIPC_A_PIN4: begin
               if (bus.wdata <= {13'h0000, `AAIPC_P14_MAX}) begin
                  next_s.pin4 = bus.wdata[2:0];
               end
            end
            default: ;
         endcase
      end

      // Register reads, data one cycle later
      if (bus.rd) begin
         unique case (bus.addr)
            `AAIPC_A_PIN3:  next_s.rdata = {11'h000, s.pin3};
            `AAIPC_A_GROUP: next_s.rdata = {15'h0000, s.group};
            `AAIPC_A_MEAN:  next_s.rdata = {14'h0000, s.mean};
            `AAIPC_A_SIG:   next_s.rdata = {14'h0000, s.sig};
            `AAIPC_A_ANGLE: next_s.rdata = {14'h0000, s.angle};
            `AAIPC_A_RANGE: next_s.rdata = {9'h000, s.range};
            `AAIPC_A_FIXED: next_s.rdata = s.fixed;
            `AAIPC_A_IVL:   next_s.rdata = {7'h00, s.ivl};
            `AAIPC_A_PIN1:  next_s.rdata = {13'h0000, s.pin1};
            `AAIPC_A_PIN4:  next_s.rdata = {13'h0000, s.pin4};
            `AAIPC_A_STAT:  next_s.rdata = {9'h000, s.heat, s.calc,
                                            s.fill_seen, s.burst_busy,
                                            s.cont_run, s.conv_busy, lvl};
            `AAIPC_A_ADC:   next_s.rdata = s.adc_val;
            default:        next_s.rdata = 16'h0000;
         endcase
      end

      // Averaging method decode
      next_s.vspd = (s.mean == 2'h0) || (s.mean == `AAIPC_MEAN_MAX);
      next_s.vang = (s.mean == 2'h0) || (s.mean == 2'h2);

      // Sticky until the next reset
      if (fill_pct > `AAIPC_FILL_PCT) begin
         next_s.fill_seen = 1'b1;
      end

      // Pin drive, pulls and heating by function
      next_s.pin = '0;
      next_s.heat = 1'b1;
      unique case (s.pin3)
         `AAIPC_FN_FILL: begin
            next_s.pin.oe = 1'b1;
            next_s.pin.out = s.fill_seen;
         end
         `AAIPC_FN_LOW: next_s.pin.oe = 1'b1;
         `AAIPC_FN_HIGH: begin
            next_s.pin.oe = 1'b1;
            next_s.pin.out = 1'b1;
         end
         `AAIPC_FN_HT_P: next_s.heat = lvl;
         `AAIPC_FN_HT_N: next_s.heat = ~lvl;
         `AAIPC_FN_HT_PU: begin
            next_s.heat = lvl;
            next_s.pin.pull_up = 1'b1;
         end
         `AAIPC_FN_HT_ND: begin
            next_s.heat = ~lvl;
            next_s.pin.pull_down = 1'b1;
         end
         `AAIPC_FN_HT_PD: begin
            next_s.heat = lvl;
            next_s.pin.pull_down = 1'b1;
         end
         `AAIPC_FN_HT_NU: begin
            next_s.heat = ~lvl;
            next_s.pin.pull_up = 1'b1;
         end
         `AAIPC_FN_TRIG, `AAIPC_FN_CONT,
         `AAIPC_FN_BST_H: next_s.pin.pull_down = 1'b1;
         `AAIPC_FN_BST_L: next_s.pin.pull_up = 1'b1;
         `AAIPC_FN_DIR: begin
            next_s.pin.oe = 1'b1;
            next_s.pin.out = wind_direction < `AAIPC_DIR_LIM;
         end
         `AAIPC_FN_HST_A, `AAIPC_FN_HST_B: begin
            next_s.pin.oe = 1'b1;
            next_s.pin.out = heating_on;
         end
         default: ;
      endcase

      // Measurement triggers
      if (s.pin3 == `AAIPC_FN_TRIG && rise) begin
         next_s.meas_start = 1'b1;
      end
      // Stop by rewriting 15; a same-cycle edge still starts
      if (bus.wr && bus.addr == `AAIPC_A_PIN3
          && bus.wdata == {11'h000, `AAIPC_FN_CONT}) begin
         next_s.cont_run = 1'b0;
      end else if (s.pin3 != `AAIPC_FN_CONT) begin
         next_s.cont_run = 1'b0;
      end
      if (s.pin3 == `AAIPC_FN_CONT && rise) begin
         next_s.cont_run = 1'b1;
      end
      if (meas_done) begin
         next_s.burst_busy = 1'b0;
      end
      // Level sensed, so a held pin restarts when the last one ends
      if (!s.burst_busy && !meas_done
          && ((s.pin3 == `AAIPC_FN_BST_H && lvl)
              || (s.pin3 == `AAIPC_FN_BST_L && !lvl))) begin
         next_s.burst_start = 1'b1;
         next_s.burst_busy = 1'b1;
      end

      // Analog path enable
      alloff = s.sig == `AAIPC_SIG_OFF && s.pin1 == 3'h0
               && s.pin4 == 3'h0 && s.pin3 == 5'h00;
      next_s.calc = !alloff;

      // Millisecond base and update pacing
      ms_tick = s.ms_cnt == 18'(CYC_PER_MS - 1);
      next_s.ms_cnt = ms_tick ? 18'h00000 : s.ms_cnt + 18'h00001;
      if (ms_tick && s.ivl_cnt < s.ivl) begin
         next_s.ivl_cnt = s.ivl_cnt + 9'h001;
      end
      if (conv_done && s.conv_busy) begin
         next_s.conv_busy = 1'b0;
         if (s.pin3 == `AAIPC_FN_AIN) begin
            next_s.adc_val = adc_code;
         end
      end

      // Scaled output values
      full = {9'h000, s.range} * `AAIPC_SPD_LSB;
      adj = {1'b0, wind_direction};
      span = `AAIPC_DEG360;
      if (s.angle == 2'h1) begin
         adj = adj + `AAIPC_OFS_WEST;
         span = `AAIPC_SPAN540;
      end else if (s.angle == `AAIPC_AO_MAX) begin
         adj = adj + `AAIPC_OFS_SOUTH;
         span = `AAIPC_SPAN720;
      end
      if (adj >= `AAIPC_DEG360) begin
         adj = adj - `AAIPC_DEG360;
      end
      tt = {{5{sound_temperature[10]}}, sound_temperature} + `AAIPC_VT_OFS;

      // Next update only once interval and conversion are both over
      if (s.calc && s.ivl != 9'h000 && !s.conv_busy
          && s.ivl_cnt >= s.ivl) begin
         next_s.conv_start = 1'b1;
         next_s.conv_busy = 1'b1;
         next_s.ivl_cnt = 9'h000;
         if (s.group) begin
            next_s.dac.speed = comp(wind_ew, full);
            next_s.dac.dir = comp(wind_ns, full);
         end else begin
            next_s.dac.speed = scale({4'h0, wind_speed}, full, `AAIPC_FULL);
            next_s.dac.dir = scale({6'h00, adj}, {6'h00, span}, `AAIPC_FULL);
         end
         next_s.dac.temp = tt[15] ? 16'h0000
                           : scale(tt, `AAIPC_VT_SPAN, `AAIPC_FULL);
         if (s.fixed != 16'h0000) begin
            next_s.dac.speed = s.fixed;
            next_s.dac.dir = s.fixed;
            next_s.dac.temp = s.fixed;
         end
      end
      next_s.dac.temp_en = s.calc && s.pin3 == `AAIPC_FN_VT
                           && s.sig != `AAIPC_SIG_OFF;
      if (!s.calc) begin
         next_s.dac = '0;
         next_s.conv_busy = 1'b0;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s <= '0;
         s.range <= `AAIPC_RANGE_RST;
         s.ivl <= `AAIPC_IVL_RST;
         s.heat <= 1'b1;
         s.calc <= 1'b1;
         s.vspd <= 1'b1;
         s.vang <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;
   assign pin = s.pin;
   assign heat_enable = s.heat;
   assign meas_start = s.meas_start;
   assign burst_start = s.burst_start;
   assign cont_run = s.cont_run;
   assign conv_start = s.conv_start;
   assign calc_enable = s.calc;
   assign vector_speed = s.vspd;
   assign vector_angle = s.vang;
   assign dac = s.dac;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_fn_range;
      s.pin3 <= `AAIPC_FN_MAX;
   endproperty
   a_fn_range: assert property (p_fn_range) else $error("pin function out of range");

   property p_trig;
      (s.pin3 == `AAIPC_FN_TRIG && s.sy2 && !s.sy3) |=> meas_start ##1 !meas_start;
   endproperty
   a_trig: assert property (p_trig) else $error("trigger edge lost");

   property p_low;
      s.pin3 == `AAIPC_FN_LOW |=> pin.oe && !pin.out;
   endproperty
   a_low: assert property (p_low) else $error("pin not driven low");

   property p_dir;
      (s.pin3 == `AAIPC_FN_DIR) |=> pin.out == ($past(wind_direction) < `AAIPC_DIR_LIM);
   endproperty
   a_dir: assert property (p_dir) else $error("direction level wrong");

   property p_heat;
      s.pin3 == `AAIPC_FN_HT_N |=> heat_enable == !$past(s.sy2);
   endproperty
   a_heat: assert property (p_heat) else $error("heating polarity wrong");

   property p_off;
      (s.sig == `AAIPC_SIG_OFF && s.pin1 == 3'h0 && s.pin4 == 3'h0 && s.pin3 == 5'h00)
         |=> !calc_enable ##1 !conv_start;
   endproperty
   a_off: assert property (p_off) else $error("analog path not disabled");

   property p_sig_lock;
      (bus.wr && bus.addr == `AAIPC_A_SIG && !half_duplex) |=> $stable(s.sig);
   endproperty
   a_sig_lock: assert property (p_sig_lock) else $error("signal type changed");

   property p_ivl0;
      s.ivl == 9'h000 |=> !conv_start;
   endproperty
   a_ivl0: assert property (p_ivl0) else $error("update with zero interval");

   property p_fixed;
      (conv_start && $past(s.fixed) != 16'h0000) |-> dac.speed == $past(s.fixed);
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed level ignored");

   property p_burst;
      (s.pin3 == `AAIPC_FN_BST_L && !s.sy2 && !s.burst_busy && !meas_done)
         |=> burst_start && pin.pull_up;
   endproperty
   a_burst: assert property (p_burst) else $error("grounded burst not started");

   property p_fill;
      (s.pin3 == `AAIPC_FN_FILL && !s.fill_seen) |=> !pin.out;
   endproperty
   a_fill: assert property (p_fill) else $error("fill output early");

endmodule
`default_nettype wire

//--- test/aaipc_far_pin.sv
// Far side of the block: pin driver, measurement core and converter.
// Assumes one 250 MHz clock; the bench calls drive and release_pin.
`timescale 1ns/100ps
`default_nettype none
module aaipc_far_pin (
   input  wire logic                  clk_sys,
   input  wire aaipc_pkg::aaipc_pin_t pin,
   input  wire logic                  conv_start,
   input  wire logic                  meas_start,
   input  wire logic                  burst_start,
   output var  logic                  conv_done,
   output var  logic                  meas_done,
   output var  logic                  pin_in
);
   import aaipc_pkg::*;
   logic drv_en = 1'b0;
   logic drv_val = 1'b0;
   // Device drive wins, then ours; open pin follows its pull resistor
   assign pin_in = pin.oe ? pin.out : drv_en ? drv_val : pin.pull_up;
   always_ff @(posedge clk_sys) begin
      conv_done <= conv_start;
      meas_done <= meas_start | burst_start;
   end
   // Level held n edges; callers keep trigger pulses over 1 us
   task automatic drive(input logic v, input int n);
      drv_en <= 1'b1;
      drv_val <= v;
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic release_pin;
      drv_en <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- test/test_anemometer_analog_io_pin_control.sv
// Bench: register tasks, then pin and analog scenarios.
// Assumes the package and the far pin model; 250 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module test_anemometer_analog_io_pin_control;
   import aaipc_pkg::*;
   logic              clk_sys = 1'b0;
   logic              rst_n = 1'b0;
   logic              half_duplex = 1'b1;
   logic              heating_on = 1'b0;
   aaipc_bus_t        bus = '0;
   aaipc_pin_t        pin;
   aaipc_dac_t        dac;
   logic [15:0]       rdata;
   logic [15:0]       adc_code = '0;
   logic [11:0]       wind_speed = '0;
   logic signed[12:0] wind_ew = '0;
   logic signed[10:0] sound_temperature = '0;
   logic [8:0]        wind_direction = '0;
   logic [6:0]        fill_pct = '0;
   logic              pin_in, heat_enable, meas_start, burst_start, cont_run;
   logic              conv_start, conv_done, meas_done, calc_enable, vs, va;
   int                mismatches = 0, n_tests = 0, n_meas, n_burst, n_conv, i;
   aaipc_pin_ctrl #(.CYC_PER_MS(4)) dut (.clk_sys, .rst_n, .bus, .rdata, .half_duplex,
      .pin_in, .pin, .wind_speed, .wind_ew, .wind_ns(wind_ew), .wind_direction,
      .sound_temperature, .fill_pct, .heating_on, .meas_done, .conv_done, .adc_code,
      .heat_enable, .meas_start, .burst_start, .cont_run, .conv_start, .calc_enable,
      .vector_speed(vs), .vector_angle(va), .dac);
   aaipc_far_pin far (.clk_sys, .pin, .conv_start, .meas_start, .burst_start,
      .conv_done, .meas_done, .pin_in);
   initial forever #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      n_meas += (meas_start === 1'b1);
      n_burst += (burst_start === 1'b1);
      n_conv += (conv_start === 1'b1);
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      bus <= '{a, v, 1'b1, 1'b0};
      @(posedge clk_sys);
      bus.wr <= 1'b0;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      bus <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge clk_sys);
      bus.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   // Update pacing is short with the small ms count
   // First step skips a pulse computed from settings older than the last write
   task automatic wait_conv;
      settle(1);
      for (i = 0; i < 200 && conv_start !== 1'b1; i++) settle(1);
      chk({15'h0, conv_start}, 16'h0001);
   endtask
   task automatic results;
      $display("tests=%0d mismatches=%0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      results();
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      rchk(4'h0, 16'h0000);
      rchk(4'h5, 16'h003C);
      rchk(4'h7, 16'h0032);
      wr(4'h0, 16'h0015);
      rchk(4'h0, 16'h0000);
      half_duplex <= 1'b0;
      wr(4'h3, 16'h0001);
      rchk(4'h3, 16'h0000);
      half_duplex <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         wr(4'h2, 16'(m));
         settle(2);
         chk({14'h0, vs, va}, {14'h0, ~(m[0] ^ m[1]), ~m[0]});
      end
      $display("registers done");
      for (int f = 5; f <= 20; f++) begin
         wr(4'h0, 16'(f));
         for (int k = 0; k < 2; k++) begin
            fill_pct <= k[0] ? 7'h51 : 7'h50;
            wind_direction <= k[0] ? 9'h0AA : 9'h0A9;
            heating_on <= k[0];
            if (f >= 8 && f <= 13)
               far.drive(k[0], 4);
            settle(3);
            if (f >= 8 && f <= 13)
               chk({15'h0, heat_enable}, {15'h0, k[0] ^ f[0]});
            if (f == 5 || f == 6 || f == 7 || f >= 18)
               chk({14'h0, pin.oe, pin.out}, {14'h0, 1'b1, f == 7 || (f == 5 || f > 18)
                  && k[0] || f == 18 && !k[0]});
         end
         if (f >= 8 && f <= 13)
            chk({14'h0, pin.pull_up, pin.pull_down}, {14'h0, f == 10 || f == 13,
               f == 11 || f == 12});
      end
      $display("pin functions done");
      wr(4'h0, 16'h000E);
      far.drive(1'b0, 8);
      n_meas = 0;
      far.drive(1'b1, 260);
      far.drive(1'b0, 8);
      chk(16'(n_meas), 16'h0001);
      wr(4'h0, 16'h000F);
      far.drive(1'b1, 260);
      far.drive(1'b0, 8);
      chk({15'h0, cont_run}, 16'h0001);
      wr(4'h0, 16'h000F);
      settle(2);
      chk({15'h0, cont_run}, 16'h0000);
      for (int f = 16; f <= 17; f++) begin
         wr(4'h0, 16'(f));
         far.release_pin();
         settle(8);
         n_burst = 0;
         settle(40);
         chk(16'(n_burst), 16'h0000);
         far.drive(f == 16, 40);
         chk({15'h0, n_burst > 1}, 16'h0001);
         far.release_pin();
      end
      $display("trigger and burst done");
      wr(4'h0, 16'h0001);
      wr(4'h1, 16'h0001);
      wr(4'h7, 16'h0001);
      adc_code <= 16'hA5C3;
      wait_conv();
      chk(dac.speed, 16'h8000);
      settle(3);
      rchk(4'hB, 16'hA5C3);
      wind_speed <= 12'h258;
      sound_temperature <= 11'sh320;
      wr(4'h0, 16'h0003);
      wr(4'h1, 16'h0000);
      wait_conv();
      wait_conv();
      chk(dac.speed, 16'hFFFF);
      chk(dac.temp, 16'hFFFF);
      chk({15'h0, dac.temp_en}, 16'h0001);
      chk(dac.dir, 16'h78E3);
      wr(4'h4, 16'h0001);
      wait_conv();
      chk(dac.dir, 16'h7B41);
      wr(4'h6, 16'h1234);
      wait_conv();
      wait_conv();
      chk(dac.dir, 16'h1234);
      wr(4'h7, 16'h0000);
      settle(10);
      n_conv = 0;
      settle(60);
      chk(16'(n_conv), 16'h0000);
      wr(4'h3, 16'h0002);
      settle(2);
      chk({15'h0, dac.temp_en}, 16'h0000);
      wr(4'h0, 16'h0000);
      settle(2);
      chk({15'h0, calc_enable}, 16'h0000);
      $display("analog done");
      results();
   end
endmodule
`default_nettype wire
